// [src/btsc_exec.sv]
// Purpose: Executes bit-test skip and subroutine call instructions
// Assumes: INSN is the word fetched at PC_ADDR, valid every cycle
// Notes: Other opcodes just advance the counter; PC_ADDR is the fetch address
`timescale 1ns/1ps
module btsc_exec (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Instruction fetch
  input wire logic [btsc_pkg::INSN_W-1:0] INSN,
  output logic [btsc_pkg::PC_W-1:0] PC_ADDR,
  // File register read path
  output logic [btsc_pkg::ADDR_W-1:0] FILE_ADDR,
  input wire logic [btsc_pkg::DATA_W-1:0] FILE_DATA,
  input wire logic [btsc_pkg::DATA_W-1:0] STATUS_DATA,
  // Stack push port
  output logic PUSH,
  output logic [btsc_pkg::PC_W-1:0] PUSH_ADDR,
  // Execution status
  output logic [btsc_pkg::INSN_W-1:0] EXEC_INSN,
  output logic SKIP_TAKEN,
  output logic STATUS_WE
);
  typedef struct packed {
    btsc_pkg::btsc_state_t state;
    logic [btsc_pkg::INSN_W-1:0] exec_insn;
    logic push;
    logic [btsc_pkg::PC_W-1:0] push_addr;
    logic skip;
  } btsc_st_t;
  btsc_st_t st;
  btsc_st_t next_st;
  logic [btsc_pkg::PC_W-1:0] pc;
  logic pc_load;
  logic [btsc_pkg::PC_W-1:0] pc_val;
  logic [3:0] op;
  logic bit_val;

  // Opcode prefix of a word
  function automatic logic [3:0] opcode(
    input logic [btsc_pkg::INSN_W-1:0] w);
    opcode = w[btsc_pkg::OP_HI:btsc_pkg::OP_LO];
  endfunction

  // Selected bit of the addressed register
  assign op = opcode(INSN);
  assign FILE_ADDR = INSN[btsc_pkg::FILE_HI:0];
  assign bit_val = FILE_DATA[INSN[btsc_pkg::BIT_HI:btsc_pkg::BIT_LO]];

  // Decode and execute
  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    next_st.skip = 1'b0;
    next_st.exec_insn = INSN;
    next_st.state = btsc_pkg::ST_RUN;
    pc_load = 1'b0;
    pc_val = pc;
    case (st.state)
      btsc_pkg::ST_FLUSH: begin
        // RULE_02: no-op replaces word
        // RULE_07: second call cycle
        next_st.exec_insn = btsc_pkg::INSN_NOP;
        // RULE_05: refetch call target
        // The target word seen in this slot is dropped, so the counter
        // holds and fetches it again; otherwise a call lands on target+1
        if (st.push) begin
          pc_load = 1'b1;
          pc_val = pc;
        end
      end
      btsc_pkg::ST_RUN: begin
        // RULE_01: skip when clear
        if (op == btsc_pkg::OP_SKIP_CLR && !bit_val) begin
          next_st.state = btsc_pkg::ST_FLUSH;
          next_st.skip = 1'b1;
        end
        // RULE_03: skip when set
        if (op == btsc_pkg::OP_SKIP_SET && bit_val) begin
          next_st.state = btsc_pkg::ST_FLUSH;
          next_st.skip = 1'b1;
        end
        // RULE_08: untaken test falls through
        if (op == btsc_pkg::OP_CALL) begin
          // RULE_04: push return address
          next_st.push = 1'b1;
          next_st.push_addr = pc + btsc_pkg::PC_ONE;
          // RULE_05: literal to low bits
          // RULE_06: page bits, bit 8 cleared
          pc_load = 1'b1;
          pc_val = {STATUS_DATA[btsc_pkg::PAGE_HI:btsc_pkg::PAGE_LO], 1'b0,
                    INSN[btsc_pkg::LIT_HI:0]};
          next_st.state = btsc_pkg::ST_FLUSH;
        end
      end
      default: begin
        next_st.state = btsc_pkg::ST_RUN;
      end
    endcase
  end

  // State flops
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st.state <= btsc_pkg::ST_RUN;
      st.exec_insn <= btsc_pkg::INSN_NOP;
      st.push <= 1'b0;
      st.push_addr <= '0;
      st.skip <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Program counter
  btsc_pc_reg u_pc (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .load(pc_load),
    .load_val(pc_val),
    .pc(pc)
  );

  assign PC_ADDR = pc;
  assign PUSH = st.push;
  assign PUSH_ADDR = st.push_addr;
  assign EXEC_INSN = st.exec_insn;
  assign SKIP_TAKEN = st.skip;
  // RULE_07: flags never written
  assign STATUS_WE = 1'b0;
endmodule

// [src/btsc_pkg.sv]
// Purpose: Constants for the bit-test skip and call execution block
// Assumes: 12-bit instruction words, 11-bit program counter
// Notes: Encodings and field positions of the three handled instructions
// Summary of operation
// RULE_01: Prefix 0110 skips the next instruction when the tested bit is zero.
// RULE_02: A taken skip discards the prefetched word; a no-op runs, two cycles.
// RULE_03: Prefix 0111 skips the next instruction when the tested bit is one.
// RULE_04: Call pushes program counter plus one onto the hardware stack first.
// RULE_05: Call loads the eight-bit literal into program counter bits 7 to 0.
// RULE_06: Call copies status bits 6:5 to counter bits 10:9, clears bit 8.
// RULE_07: Call always takes two cycles and changes no status flag.
// RULE_08: An untaken test runs the next word normally in one cycle, no flags.
package btsc_pkg;
  localparam int INSN_W = 12;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam logic [3:0] OP_SKIP_CLR = 4'h6;
  localparam logic [3:0] OP_SKIP_SET = 4'h7;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int BIT_HI = 7;
  localparam int BIT_LO = 5;
  localparam int FILE_HI = 4;
  localparam int LIT_HI = 7;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 5;
  localparam logic [PC_W-1:0] PC_RESET = 11'h7FF;
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [INSN_W-1:0] INSN_NOP = 12'h000;
  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_FLUSH = 1'b1
  } btsc_state_t;
endpackage

// [src/btsc_pc_reg.sv]
// Purpose: Program counter register with load and increment
// Assumes: One load or increment per cycle
// Notes: Load has priority over increment
`timescale 1ns/1ps
module btsc_pc_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic load,
  input wire logic [btsc_pkg::PC_W-1:0] load_val,
  // Value
  output logic [btsc_pkg::PC_W-1:0] pc
);
  typedef struct packed {
    logic [btsc_pkg::PC_W-1:0] pc;
  } btsc_pcs_t;
  btsc_pcs_t st;
  btsc_pcs_t next_st;

  // Next counter value
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.pc = load_val;
    end else begin
      next_st.pc = st.pc + btsc_pkg::PC_ONE;
    end
  end

  // Counter flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.pc <= btsc_pkg::PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign pc = st.pc;
endmodule

// [sim/btsc_chk.sv]
// Purpose: Port checker for skip and call execution
// Assumes: The word seen while SKIP_TAKEN or PUSH is high is a flushed slot
// Notes: Bound to btsc_exec below
`timescale 1ns/1ps
module btsc_chk (
  // Watched ports
  input wire logic CLK_SYS, RSTN, PUSH, SKIP_TAKEN, STATUS_WE,
  input wire logic [11:0] INSN, EXEC_INSN,
  input wire logic [10:0] PC_ADDR, PUSH_ADDR,
  input wire logic [4:0] FILE_ADDR,
  input wire logic [7:0] FILE_DATA, STATUS_DATA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Decode slot, opcode and tested bit
  logic v, b;
  logic [3:0] op;
  assign v = !PUSH && !SKIP_TAKEN;
  assign op = INSN[11:8];
  assign b = FILE_DATA[INSN[7:5]];
  a_skip_clear: assert property (v && op == 4'h6 && !b
    |=> SKIP_TAKEN) else $error("clear bit skip missed");
  a_skip_set: assert property (v && op == 4'h7 && b
    |=> SKIP_TAKEN) else $error("set bit skip missed");
  a_file_addr: assert property (FILE_ADDR == INSN[4:0])
    else $error("bad file address");
  a_skip_nop: assert property (SKIP_TAKEN |=> EXEC_INSN == 12'h000)
    else $error("skipped slot not a nop");
  a_call_push: assert property (v && op == 4'h9 |=> PUSH &&
    PUSH_ADDR == $past(PC_ADDR) + 11'h001) else $error("bad return push");
  a_call_low: assert property (v && op == 4'h9 |=>
    PC_ADDR[7:0] == $past(INSN[7:0])) else $error("bad call literal");
  a_call_page: assert property (v && op == 4'h9 |=>
    PC_ADDR[10:8] == {$past(STATUS_DATA[6:5]), 1'b0}) else $error("bad page");
  a_call_two: assert property (PUSH |=> (EXEC_INSN == 12'h000) [*1])
    else $error("call not two cycles");
  a_call_hold: assert property (PUSH |=> PC_ADDR == $past(PC_ADDR))
    else $error("call target not refetched");
  a_flags_kept: assert property (!STATUS_WE)
    else $error("status written");
  a_test_pass: assert property (
    v && (op == 4'h6 && b || op == 4'h7 && !b) |=> !SKIP_TAKEN &&
    EXEC_INSN == $past(INSN) && PC_ADDR == $past(PC_ADDR) + 11'h001)
    else $error("bad untaken test");
endmodule
bind btsc_exec btsc_chk chk (.CLK_SYS, .RSTN, .PUSH, .SKIP_TAKEN, .STATUS_WE,
  .INSN, .EXEC_INSN, .PC_ADDR, .PUSH_ADDR, .FILE_ADDR, .FILE_DATA,
  .STATUS_DATA);

// [sim/test_bit_test_skip_and_call_exec.sv]
// Purpose: Random and corner stream test of skip and call execution
// Assumes: Inputs driven at the falling edge
// Notes: A bench model predicts every output
`timescale 1ns/1ps
`define CK(n, e, s) total_checks++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end
module test_bit_test_skip_and_call_exec;
  logic CLK_SYS = 0, RSTN = 0, PUSH, SKIP_TAKEN, STATUS_WE, x_sk, x_pu, f, h;
  logic [11:0] INSN = 0, EXEC_INSN, x_ex;
  logic [7:0] FILE_DATA = 0, STATUS_DATA = 0;
  logic [10:0] PC_ADDR, PUSH_ADDR, x_pc, x_pa;
  logic [4:0] FILE_ADDR;
  logic [11:0] ci [4] = '{12'h9ff, 12'h900, 12'h7ff, 12'h600};
  int n_fail = 0, total_checks = 0, cyc = 0;
  btsc_exec DUT (.CLK_SYS, .RSTN, .INSN, .PC_ADDR, .FILE_ADDR, .FILE_DATA,
    .STATUS_DATA, .PUSH, .PUSH_ADDR, .EXEC_INSN, .SKIP_TAKEN, .STATUS_WE);
  // Clock and hang limit
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  // Summary and verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Expected skip decision of a decoded word
  function automatic logic skip_due(input logic [11:0] w,
    input logic [7:0] d);
    logic t;
    t = d[w[7:5]];
    return (w[11:8] == 4'h6) ? !t : (w[11:8] == 4'h7 && t);
  endfunction
  // Expected call target from literal and page bits
  function automatic logic [10:0] call_pc(input logic [11:0] w,
    input logic [7:0] s);
    return {s[6:5], 1'b0, w[7:0]};
  endfunction
  // Drive a stream and compare with the model
  initial begin
    void'($urandom(32'hab3b_111e));
    {x_ex, x_sk, x_pu, x_pa, x_pc} = {12'h000, 2'b00, 11'h000, 11'h7ff};
    repeat (12) @(negedge CLK_SYS);
    `CK("rst pc", x_pc, PC_ADDR)
    `CK("rst push", 1'b0, PUSH)
    `CK("rst exec", 12'h000, EXEC_INSN)
    RSTN = 1;
    for (int i = 0; i < 3000; i++) begin
      INSN = $urandom;
      INSN[11:8] = ($urandom % 2) ? 4'h9 : 4'h6 + 4'($urandom % 2);
      if ($urandom % 2) INSN[11:8] = 4'($urandom);
      {FILE_DATA, STATUS_DATA} = 16'($urandom);
      if (i < 4) {INSN, FILE_DATA, STATUS_DATA} = {ci[i], 16'hff60};
      f = x_sk | x_pu;
      h = x_pu;
      x_ex = f ? 12'h000 : INSN;
      x_sk = !f && skip_due(INSN, FILE_DATA);
      x_pu = !f && INSN[11:8] == 4'h9;
      x_pa = x_pc + 11'h001;
      // Counter holds in the slot after a call so the target is refetched
      x_pc = x_pu ? call_pc(INSN, STATUS_DATA) : (h ? x_pc : x_pa);
      @(negedge CLK_SYS);
      `CK("faddr", INSN[4:0], FILE_ADDR)
      `CK("exec", x_ex, EXEC_INSN)
      `CK("skip", x_sk, SKIP_TAKEN)
      `CK("pc", x_pc, PC_ADDR)
      `CK("push", x_pu, PUSH)
      if (x_pu) begin `CK("ret", x_pa, PUSH_ADDR) end
      `CK("swe", 1'b0, STATUS_WE)
    end
    give_verdict();
  end
endmodule
